// ### src/swt_map.svh
// register offsets, field positions and reset values of the watchdog timer
`ifndef SWT_MAP_SVH
`define SWT_MAP_SVH
`define SWT_RELOAD_ADDR     32'hffff0360
`define SWT_VALUE_ADDR      32'hffff0364
`define SWT_CONFIG_ADDR     32'hffff0368
`define SWT_KICK_ADDR       32'hffff036c
`define SWT_VALUE_RST       16'hffff
`define SWT_RELOAD_RST      16'h0000
`define SWT_CONFIG_RST      9'h000
`define SWT_LFSR_RST        8'h00
`define SWT_LFSR_TAPS       8'h63
`define SWT_BIT_UP          8
`define SWT_BIT_EN          7
`define SWT_BIT_PERIODIC    6
`define SWT_BIT_WDOG        5
`define SWT_BIT_SECURE      4
`define SWT_BIT_PRE_HI      3
`define SWT_BIT_PRE_LO      2
`define SWT_BIT_IRQ_OPT     1
`define SWT_CONFIG_MASK     9'h1fe
`define SWT_DIV16_LAST      8'h0f
`define SWT_DIV256_LAST     8'hff
`define SWT_HTRANS_NONSEQ   2'b10
`endif

// ### src/swt_pkg.sv
// types shared by the watchdog timer
package swt_pkg;
   typedef enum logic [1:0] {
      SWT_DIV1   = 2'b00,
      SWT_DIV16  = 2'b01,
      SWT_DIV256 = 2'b10,
      SWT_DIVX   = 2'b11
   } swt_pre_e;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic        valid;
   } swt_req_s;
endpackage

// ### src/swt_watchdog_timer.sv
// 16-bit timer with watchdog mode and secure clear, AHB-Lite slave
// Notes on behaviour
// RL1: counter_value reads live count, resets to ffff
// RL2: config bit 8 set counts up
// RL3: config bit 7 enables the timer
// RL4: config bit 6 selects periodic mode
// RL5: config bit 5 enters watchdog mode
// RL6: config bit 4 enables secure clear
// RL7: prescale bits 3:2, code 11 acts as 00
// RL8: config bit 1 makes expiry an interrupt
// RL9: kick clears interrupt or restarts timeout
// RL10: software kicks repeatedly to keep period alive
// RL11: secure kick compared against expected value
// RL12: expected values from x8+x6+x5+x+1 lfsr
// RL13: kick before watchdog mode loads the seed
// RL14: matching kick reloads counter, advances lfsr
// RL15: mismatching kick resets chip at once
// RL16: kick value 00 forces reset whenever secure clear is on in watchdog mode
// RL17: lfsr state is never readable
// RL18: watchdog counts down from reload to zero
// RL19: service reloads counter from reload register
// RL20: reload and config locked in watchdog mode
// RL21: software writes reload before setting watchdog
// RL22: lfsr shifts left, xor 63 on carry
// RL23: without secure clear any kick services
`timescale 1ns/10ps
`include "swt_map.svh"
module swt_watchdog_timer
   import swt_pkg::*;
#(
   parameter int CNT_W  = 16,
   parameter int LFSR_W = 8
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             timer_irq,
   output logic             chip_reset_req
);
   swt_req_s          req;
   logic [CNT_W-1:0]  count;
   logic [CNT_W-1:0]  reload_value;
   logic [8:0]        cfg;
   logic [LFSR_W-1:0] lfsr;
   logic [7:0]  pre_cnt;
   logic [7:0]  pre_last;
   logic        tick;
   logic        wr_cfg;
   logic        wr_reload;
   logic        wr_kick;
   logic        wdog;
   logic        secure;
   logic        kick_ok;
   logic        kick_bad;
   logic        at_end;
   logic [CNT_W-1:0]  next_count;

   // the register map and the feedback taps are fixed to these sizes
   if (CNT_W != 16 || LFSR_W != 8) begin : g_bad_size
      $error("only a 16-bit count and an 8-bit lfsr are supported");
   end

   // an address phase is taken only on a nonsequential transfer with the bus ready
   function automatic logic bus_start(input logic       s,
                                      input logic [1:0] t,
                                      input logic       r);
      return s && (t == `SWT_HTRANS_NONSEQ) && r;
   endfunction

   // hsize is ignored: only full-word accesses are expected
   function automatic logic [7:0] lfsr_step(input logic [7:0] s);
      lfsr_step = s[7] ? ({s[6:0], 1'b0} ^ `SWT_LFSR_TAPS) : {s[6:0], 1'b0}; // [RL12] [RL22]
   endfunction

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         req <= '0;
      end else if (hready) begin
         req.addr  <= haddr;
         req.write <= hwrite;
         req.valid <= bus_start(hsel, htrans, 1'b1);
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign wdog      = cfg[`SWT_BIT_WDOG];
   assign secure    = wdog && cfg[`SWT_BIT_SECURE]; // [RL6]
   assign wr_cfg    = req.valid && req.write && (req.addr == `SWT_CONFIG_ADDR) && !wdog; // [RL20]
   assign wr_reload = req.valid && req.write && (req.addr == `SWT_RELOAD_ADDR) && !wdog; // [RL20]
   assign wr_kick   = req.valid && req.write && (req.addr == `SWT_KICK_ADDR);
   // zero never matches since the lfsr cannot reach zero from a nonzero seed
   assign kick_bad  = wr_kick && secure
                      && ((hwdata[7:0] != lfsr) || (hwdata[7:0] == 8'h00)); // [RL11] [RL15] [RL16]
   assign kick_ok   = wr_kick && !kick_bad; // [RL23]

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_start(hsel, htrans, hready) && !hwrite) begin
         if (haddr == `SWT_VALUE_ADDR) begin
            hrdata <= {16'h0000, count}; // [RL1]
         end else if (haddr == `SWT_CONFIG_ADDR) begin
            hrdata <= {23'h0, cfg};
         end else if (haddr == `SWT_RELOAD_ADDR) begin
            hrdata <= {16'h0000, reload_value};
         end else begin
            hrdata <= 32'h0000_0000; // [RL17]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg <= `SWT_CONFIG_RST;
      end else if (wr_cfg) begin
         cfg <= hwdata[8:0] & `SWT_CONFIG_MASK; // [RL2] [RL3] [RL4] [RL5] [RL8]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reload_value <= `SWT_RELOAD_RST;
      end else if (wr_reload) begin
         reload_value <= hwdata[15:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lfsr <= `SWT_LFSR_RST;
      end else if (wr_kick && !wdog) begin
         lfsr <= hwdata[7:0]; // [RL13]
      end else if (kick_ok && secure) begin
         lfsr <= lfsr_step(lfsr); // [RL14]
      end
   end

   always_comb begin
      case (swt_pre_e'(cfg[`SWT_BIT_PRE_HI:`SWT_BIT_PRE_LO]))
         SWT_DIV16:  pre_last = `SWT_DIV16_LAST;
         SWT_DIV256: pre_last = `SWT_DIV256_LAST;
         default:    pre_last = 8'h00; // [RL7]
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pre_cnt <= 8'h00;
      end else if (!cfg[`SWT_BIT_EN] || pre_cnt >= pre_last) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   assign tick   = cfg[`SWT_BIT_EN] && (pre_cnt >= pre_last); // [RL3] [RL7]
   // watchdog always counts down regardless of the direction bit
   assign at_end = (wdog || !cfg[`SWT_BIT_UP]) ? (count == 16'h0000) : (count == 16'hffff);

   always_comb begin
      next_count = count;
      if (kick_ok && wdog) begin
         next_count = reload_value; // [RL9] [RL19]
      end else if (tick) begin
         if (wdog) begin
            next_count = (count == 16'h0000) ? count : count - 16'h0001; // [RL18]
         end else if (at_end && cfg[`SWT_BIT_PERIODIC]) begin
            next_count = reload_value; // [RL4]
         end else if (cfg[`SWT_BIT_UP]) begin
            next_count = count + 16'h0001; // [RL2]
         end else begin
            next_count = count - 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count <= `SWT_VALUE_RST; // [RL1]
      end else begin
         count <= next_count;
      end
   end

   // interrupt set wins over a kick arriving in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timer_irq <= 1'b0;
      end else if (tick && at_end && (!wdog || cfg[`SWT_BIT_IRQ_OPT])) begin
         timer_irq <= 1'b1; // [RL8]
      end else if (kick_ok) begin
         timer_irq <= 1'b0; // [RL9]
      end
   end

   // held until the system reset removes it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chip_reset_req <= 1'b0;
      end else if (kick_bad) begin
         chip_reset_req <= 1'b1; // [RL15] [RL16]
      end else if (wdog && tick && at_end && !cfg[`SWT_BIT_IRQ_OPT] && !kick_ok) begin
         chip_reset_req <= 1'b1; // [RL8] [RL18]
      end
   end

   a_bad_kick_reset: assert property (@(posedge sys_clk) disable iff (rst)
      kick_bad |=> chip_reset_req)
      else $error("bad kick did not reset"); // [RL15]
   a_zero_kick_reset: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_kick && secure && hwdata[7:0] == 8'h00) |=> chip_reset_req)
      else $error("zero kick did not reset"); // [RL16]
   a_kick_reload: assert property (@(posedge sys_clk) disable iff (rst)
      (kick_ok && wdog) |=> count == $past(reload_value))
      else $error("kick did not reload"); // [RL19]
   a_lfsr_advance: assert property (@(posedge sys_clk) disable iff (rst)
      (kick_ok && secure) |=> lfsr == lfsr_step($past(lfsr)))
      else $error("lfsr did not advance"); // [RL14]
   a_cfg_locked: assert property (@(posedge sys_clk) disable iff (rst)
      wdog |=> $stable(cfg) && $stable(reload_value))
      else $error("locked register changed"); // [RL20]
   a_stopped_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (!cfg[`SWT_BIT_EN] && !(kick_ok && wdog)) |=> $stable(count))
      else $error("disabled counter moved"); // [RL3]
   a_wdog_down: assert property (@(posedge sys_clk) disable iff (rst)
      (wdog && tick && !kick_ok && count != 16'h0000) |=> count == $past(count) - 16'h0001)
      else $error("watchdog did not count down"); // [RL18]
   a_expiry_irq: assert property (@(posedge sys_clk) disable iff (rst)
      (wdog && tick && at_end && cfg[`SWT_BIT_IRQ_OPT] && !kick_bad && !chip_reset_req)
      |=> timer_irq && !chip_reset_req)
      else $error("irq option expiry wrong"); // [RL8]
   a_seed_load: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_kick && !wdog) |=> lfsr == $past(hwdata[7:0]))
      else $error("seed not loaded"); // [RL13]
   a_up_count: assert property (@(posedge sys_clk) disable iff (rst)
      (tick && !wdog && cfg[`SWT_BIT_UP] && !at_end) |=> count == $past(count) + 16'h0001)
      else $error("up count wrong"); // [RL2]

   a_down_count: assert property (@(posedge sys_clk) disable iff (rst)
      (tick && !wdog && !cfg[`SWT_BIT_UP] && !at_end) |=> count == $past(count) - 16'h0001)
      else $error("down count wrong"); // [RL2]

   a_periodic_load: assert property (@(posedge sys_clk) disable iff (rst)
      (tick && !wdog && at_end && cfg[`SWT_BIT_PERIODIC]) |=> count == $past(reload_value))
      else $error("periodic reload missing"); // [RL4]

   a_expiry_reset: assert property (@(posedge sys_clk) disable iff (rst)
      (wdog && tick && at_end && !cfg[`SWT_BIT_IRQ_OPT] && !kick_ok) |=> chip_reset_req)
      else $error("expiry did not reset"); // [RL8]

   // a reset request must never fall back on its own; only rst may clear it
   a_reset_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      chip_reset_req |=> chip_reset_req)
      else $error("reset request dropped"); // [RL15]

   a_irq_kick_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (kick_ok && !(tick && at_end && (!wdog || cfg[`SWT_BIT_IRQ_OPT]))) |=> !timer_irq)
      else $error("kick left irq set"); // [RL9]

   a_wdog_hold_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (wdog && count == 16'h0000 && !kick_ok) |=> count == 16'h0000)
      else $error("watchdog left zero"); // [RL18]

   a_plain_kick_ok: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_kick && !secure) |=> !$past(kick_bad))
      else $error("plain kick refused"); // [RL23]

   a_kick_hidden: assert property (@(posedge sys_clk) disable iff (rst)
      (bus_start(hsel, htrans, hready) && !hwrite && haddr == `SWT_KICK_ADDR)
      |=> hrdata == 32'h0000_0000)
      else $error("kick register readable"); // [RL17]

   // zero wait states and an always-okay response keep the bus model trivial
   a_bus_okay: assert property (@(posedge sys_clk) disable iff (rst)
      hreadyout && !hresp)
      else $error("bus response not okay");
endmodule

// ### dv/swt_watchdog_timer_tb.sv
// self-checking bench for the watchdog timer, driving the AHB-Lite port directly
`timescale 1ns/10ps
`include "swt_map.svh"
module swt_watchdog_timer_tb
   import swt_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic        hreadyout;
   logic        hresp;
   logic        timer_irq;
   logic        chip_reset_req;
   int          cyc = 0;
   int          stamp;
   int          n_fail = 0;
   int          tests_run = 0;

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;

   swt_watchdog_timer u_swt_watchdog_timer (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_irq(timer_irq), .chip_reset_req(chip_reset_req));

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // one single transfer; read data is taken at the edge that ends the data phase
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `SWT_HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      q = hrdata;
      stamp = cyc;
   endtask

   task automatic do_rst;
      rst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask

   // count change over exactly k cycles; whole prescale periods make it phase-independent
   task automatic rate(input int k, output logic [15:0] dv);
      logic [15:0] v1;
      int          t0;
      bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
      v1 = q[15:0];
      t0 = stamp;
      repeat (k - 2) @(posedge sys_clk);
      bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
      chk("sample span", k, stamp - t0);
      dv = q[15:0] - v1;
   endtask

   task automatic t_reset;
      bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
      chk("value reset", 32'hffff, q);
      bus(1'b0, `SWT_CONFIG_ADDR, 32'h0);
      chk("config reset", 32'h0, q);
      bus(1'b1, `SWT_VALUE_ADDR, 32'h1234);
      bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
      chk("value read only", 32'hffff, q);
      bus(1'b0, `SWT_KICK_ADDR, 32'h0);
      chk("kick reads", 32'h0, q);
      bus(1'b0, 32'hffff0370, 32'h0);
      chk("unmapped", 32'h0, q);
      chk("hresp okay", 32'h0, hresp);
      chk("hreadyout", 32'h1, hreadyout);
   endtask

   task automatic t_prescale;
      logic [15:0] dv;
      int          dvs[4] = '{1, 16, 256, 1};
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, `SWT_CONFIG_ADDR, 32'h80 | (c << 2));
         rate(4 * dvs[c], dv);
         chk("down rate", 32'hfffc, dv);
      end
      bus(1'b1, `SWT_CONFIG_ADDR, 32'h0);
      rate(8, dv);
      chk("stopped", 32'h0, dv);
   endtask

   task automatic t_up_irq;
      logic [15:0] dv;
      do_rst;
      bus(1'b1, `SWT_CONFIG_ADDR, 32'h1c1);
      bus(1'b0, `SWT_CONFIG_ADDR, 32'h0);
      chk("config readback", 32'h1c0, q);
      for (int i = 0; i < 20 && timer_irq !== 1'b1; i++) @(posedge sys_clk);
      chk("end irq", 32'h1, timer_irq);
      rate(8, dv);
      chk("up rate", 32'h8, dv);
      bus(1'b1, `SWT_KICK_ADDR, 32'h5a);
      repeat (2) @(posedge sys_clk);
      chk("kick clears irq", 32'h0, timer_irq);
   endtask

   // div16 keeps the kick off a tick edge at zero, where a new irq would win
   task automatic t_wdog(input logic opt);
      do_rst;
      bus(1'b1, `SWT_RELOAD_ADDR, 32'h20);
      bus(1'b1, `SWT_CONFIG_ADDR, 32'ha4 | (opt << 1));
      bus(1'b1, `SWT_KICK_ADDR, 32'h55);
      bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
      chk("kick reload", 32'h1, q <= 32'h20 && q > 32'h1c);
      bus(1'b1, `SWT_CONFIG_ADDR, 32'h0);
      bus(1'b1, `SWT_RELOAD_ADDR, 32'h300);
      bus(1'b0, `SWT_CONFIG_ADDR, 32'h0);
      chk("config locked", 32'ha4 | (opt << 1), q);
      bus(1'b0, `SWT_RELOAD_ADDR, 32'h0);
      chk("reload locked", 32'h20, q);
      for (int i = 0; i < 700 && timer_irq !== 1'b1 && chip_reset_req !== 1'b1; i++)
         @(posedge sys_clk);
      chk("expiry irq", opt, timer_irq);
      chk("expiry reset", !opt, chip_reset_req);
      bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
      chk("at zero", 32'h0, q);
      if (opt) begin
         bus(1'b1, `SWT_KICK_ADDR, 32'h11);
         repeat (2) @(posedge sys_clk);
         chk("wdog irq clear", 32'h0, timer_irq);
      end
   endtask

   task automatic t_secure(input logic [7:0] bad, input int n);
      logic [7:0] x;
      x = 8'haa;
      do_rst;
      bus(1'b1, `SWT_KICK_ADDR, 32'haa);
      bus(1'b1, `SWT_RELOAD_ADDR, 32'h200);
      bus(1'b1, `SWT_CONFIG_ADDR, 32'hb0);
      repeat (n) begin
         bus(1'b1, `SWT_KICK_ADDR, {24'h0, x});
         repeat (2) @(posedge sys_clk);
         chk("good kick", 32'h0, chip_reset_req);
         bus(1'b0, `SWT_VALUE_ADDR, 32'h0);
         chk("secure reload", 32'h1, q > 32'h1f0);
         x = {x[6:0], 1'b0} ^ (x[7] ? 8'h63 : 8'h00);
      end
      bus(1'b0, `SWT_KICK_ADDR, 32'h0);
      chk("lfsr hidden", 32'h0, q);
      bus(1'b1, `SWT_KICK_ADDR, {24'h0, bad});
      repeat (2) @(posedge sys_clk);
      chk("bad kick", 32'h1, chip_reset_req);
   endtask

   initial begin
      #200000;
      n_fail++;
      wrap_up;
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      t_prescale;
      t_up_irq;
      t_wdog(1'b0);
      t_wdog(1'b1);
      t_secure(8'h66, 3);
      t_secure(8'h00, 0);
      wrap_up;
   end
endmodule
